// [verilog/display_command_decoder_defines.svh]
`ifndef DISPLAY_COMMAND_DECODER_DEFINES_SVH
`define DISPLAY_COMMAND_DECODER_DEFINES_SVH

// ==========================================
// command codes
`define CMD_MASTER_RESET 8'h00
`define CMD_RD_PTR 8'ha4
`define CMD_WR_PTR 8'ha2
`define CMD_INC_CUR 8'ha9
`define CMD_RD_CUR 8'hac
`define CMD_WR_CUR 8'haa
`define CMD_RD_CUR_INC 8'had
`define CMD_WR_CUR_INC 8'hab
`define CMD_BLOCK_WR 8'hbb
`define CMD_BLOCK_RD 8'hbd
`define PFX_LOAD_IR 4'h1
`define PFX_MODE 3'h1
`define PFX_CLR_STATUS 3'h2
`define PFX_SET_MASK 3'h3
`define PFX_CLR_MASK 3'h4
`define IR_PTR_MAX 4'he

// ==========================================
// status bit positions
`define BIT_SPLIT2 0
`define BIT_READY 1
`define BIT_SPLIT1 2
`define BIT_LINE0 3
`define BIT_VBLANK 4

// ==========================================
// timing and bus widths
`define INC_TIME_CHARACTER_CLOCK 3
`define ADDR_WIDTH 14
`define DATA_WIDTH 8

`endif

// [verilog/display_command_pkg.sv]
package display_command_pkg;

   typedef enum logic [4:0] {
      st_idle = 5'h01,
      st_wait = 5'h02,
      st_xfer = 5'h04,
      st_inc = 5'h08,
      st_done = 5'h10
   } engine_state_type;

   typedef enum logic [3:0] {
      op_rd_ptr = 4'h0,
      op_wr_ptr = 4'h1,
      op_inc = 4'h2,
      op_rd_cur = 4'h3,
      op_wr_cur = 4'h4,
      op_rd_cur_inc = 4'h5,
      op_wr_cur_inc = 4'h6,
      op_block_wr = 4'h7,
      op_block_rd = 4'h8
   } delayed_op_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [13:0] addr;
      logic [7:0] wdata;
   } mem_req_type;

   typedef struct packed {
      logic valid;
      logic delayed;
      delayed_op_type op;
   } decoded_type;

endpackage

// [verilog/pin_sync.sv]
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // ==========================================
   // two-stage synchroniser
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// [verilog/command_classifier.sv]
`include "display_command_decoder_defines.svh"

module command_classifier (
   input wire logic [7:0] cmd,
   output display_command_pkg::decoded_type dec
);
   // ==========================================
   // delayed code lookup, anything else is not delayed
   always_comb begin
      dec = '{valid: 1'b0, delayed: 1'b0, op: display_command_pkg::op_rd_ptr};
      case (cmd)
         `CMD_RD_PTR: dec = '{1'b1, 1'b1, display_command_pkg::op_rd_ptr};
         `CMD_WR_PTR: dec = '{1'b1, 1'b1, display_command_pkg::op_wr_ptr};
         `CMD_INC_CUR: dec = '{1'b1, 1'b1, display_command_pkg::op_inc};
         `CMD_RD_CUR: dec = '{1'b1, 1'b1, display_command_pkg::op_rd_cur};
         `CMD_WR_CUR: dec = '{1'b1, 1'b1, display_command_pkg::op_wr_cur};
         `CMD_RD_CUR_INC: dec = '{1'b1, 1'b1, display_command_pkg::op_rd_cur_inc};
         `CMD_WR_CUR_INC: dec = '{1'b1, 1'b1, display_command_pkg::op_wr_cur_inc};
         `CMD_BLOCK_WR: dec = '{1'b1, 1'b1, display_command_pkg::op_block_wr};
         `CMD_BLOCK_RD: dec = '{1'b1, 1'b1, display_command_pkg::op_block_rd};
         default: dec = '{valid: 1'b0, delayed: 1'b0, op: display_command_pkg::op_rd_ptr};
      endcase
   end
endmodule

// [verilog/display_command_decoder.sv]
`include "display_command_decoder_defines.svh"

// How it works
// - prefix 0001 loads pointer, values 0..14
// - display on at next field or line
// - graphics, display, cursor selections combine
// - prefix 010 clears status bits
// - prefix 100 clears mask bits
// - prefix 011 sets mask bits
// - a4 reads, a2 writes at pointer
// - ac reads, aa writes, a9 increments cursor
// - ad, ab transfer then increment cursor
// - bb block write, bd block read
// - wait for blanking unless retrace or off
// - increment starts now, about three clocks
// - block write pauses through active display
// - completion sets ready and delayed-ready
// - pointer transfers use pointer address
// - cursor transfers use cursor address
// - cursor increment wraps modulo 16k
// - transfer first, then cursor advance
// - block write inclusive, cursor ends at pointer
// - block read inclusive, cursor ends at pointer
// - low bits: split2 ready split1 line0 vblank
// - instantaneous on write end, flags untouched
// - delayed-ready low while busy
module display_command_decoder (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmd_write_n,
   input wire logic [7:0] cmd_data,
   input wire logic hblank,
   input wire logic vblank,
   input wire logic field_start,
   input wire logic line_start,
   input wire logic [4:0] status_events,
   input wire logic [13:0] pointer_addr,
   input wire logic [13:0] cursor_load,
   input wire logic cursor_load_en,
   input wire logic [7:0] latch_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   output display_command_pkg::mem_req_type mem,
   output logic [7:0] latch_rdata,
   output logic latch_rvalid,
   output logic [13:0] cursor_addr,
   output logic [3:0] init_register,
   output logic [4:0] status_bits,
   output logic [4:0] interrupt_mask,
   output logic delayed_ready_flag,
   output logic interrupt_request_output,
   output logic blank_out,
   output logic display_address_float,
   output logic graphics_enable,
   output logic cursor_enable,
   output logic master_reset_pulse
);
   // ==========================================
   // pin synchronisation
   logic [4:0] sync_pins;
   logic wr_n_s;
   logic hblank_s;
   logic vblank_s;
   logic field_s;
   logic line_s;
   pin_sync #(.WIDTH(5)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .async_in({cmd_write_n, hblank, vblank, field_start, line_start}),
      .sync_out(sync_pins)
   );
   assign {wr_n_s, hblank_s, vblank_s, field_s, line_s} = sync_pins;

   // ==========================================
   // command capture on strobe trailing edge
   logic wr_n_d;
   logic strobe_armed;
   logic [7:0] cmd_hold;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_n_d <= 1'b1;
         strobe_armed <= 1'b0;
         cmd_hold <= 8'h00;
      end else begin
         wr_n_d <= wr_n_s;
         // synchroniser clears low, so its first rise is no command
         strobe_armed <= strobe_armed | wr_n_s;
         if (!wr_n_s) begin
            cmd_hold <= cmd_data;
         end
      end
   end
   // data held while strobe low, so use the captured byte at the rising edge
   wire cmd_fire = wr_n_s & ~wr_n_d & strobe_armed;

   display_command_pkg::decoded_type dec;
   command_classifier u_class (
      .cmd(cmd_hold),
      .dec(dec)
   );

   wire is_reset = cmd_fire && cmd_hold == `CMD_MASTER_RESET;
   wire is_load_ir = cmd_fire && cmd_hold[7:4] == `PFX_LOAD_IR
      && cmd_hold[3:0] <= `IR_PTR_MAX;
   wire is_mode = cmd_fire && cmd_hold[7:5] == `PFX_MODE;
   wire is_clr_st = cmd_fire && cmd_hold[7:5] == `PFX_CLR_STATUS;
   wire is_set_mask = cmd_fire && cmd_hold[7:5] == `PFX_SET_MASK;
   wire is_clr_mask = cmd_fire && cmd_hold[7:5] == `PFX_CLR_MASK;
   // unknown delayed codes never start the engine
   wire is_delayed = cmd_fire && dec.valid && dec.delayed;

   // ==========================================
   // instantaneous state
   logic pending_on;
   logic pending_on_field;
   always_ff @(posedge sys_clk) begin
      if (rst || is_reset) begin
         init_register <= 4'h0;
         graphics_enable <= 1'b0;
         cursor_enable <= 1'b0;
         blank_out <= 1'b1;
         display_address_float <= 1'b0;
         pending_on <= 1'b0;
         pending_on_field <= 1'b0;
      end else begin
         if (is_load_ir) begin
            init_register <= cmd_hold[3:0];
         end
         if (is_mode && cmd_hold[1]) begin
            graphics_enable <= cmd_hold[0];
         end
         if (is_mode && cmd_hold[4]) begin
            cursor_enable <= cmd_hold[0];
         end
         if (is_mode && cmd_hold[3] && !cmd_hold[0]) begin
            blank_out <= 1'b1;
            display_address_float <= cmd_hold[2];
            pending_on <= 1'b0;
         end else if (is_mode && cmd_hold[3] && cmd_hold[0]) begin
            display_address_float <= 1'b0;
            pending_on <= 1'b1;
            pending_on_field <= cmd_hold[2];
         end else if (pending_on && (pending_on_field ? field_s : line_s)) begin
            blank_out <= 1'b0;
            pending_on <= 1'b0;
         end
      end
   end

   // ==========================================
   // delayed command engine
   display_command_pkg::engine_state_type state;
   display_command_pkg::engine_state_type next_state;
   display_command_pkg::delayed_op_type op;
   logic [2:0] inc_count;
   logic done_pulse;

   // blanking window: horizontal or vertical, or display forced off
   wire in_blank = hblank_s | vblank_s | blank_out;
   wire immediate = vblank_s | blank_out;
   wire op_ptr = op == display_command_pkg::op_rd_ptr || op == display_command_pkg::op_wr_ptr;
   wire op_write = op == display_command_pkg::op_wr_ptr || op == display_command_pkg::op_wr_cur
      || op == display_command_pkg::op_wr_cur_inc || op == display_command_pkg::op_block_wr;
   wire op_block = op == display_command_pkg::op_block_wr || op == display_command_pkg::op_block_rd;
   wire op_incs = op == display_command_pkg::op_rd_cur_inc
      || op == display_command_pkg::op_wr_cur_inc;
   wire [13:0] xfer_addr = op_ptr ? pointer_addr : cursor_addr;
   wire block_last = cursor_addr == pointer_addr;
   wire [13:0] cursor_plus = cursor_addr + 14'h0001;
   wire inc_end = inc_count == 3'(`INC_TIME_CHARACTER_CLOCK - 1);

   always_comb begin
      next_state = state;
      case (state)
         display_command_pkg::st_idle: begin
            if (is_delayed) begin
               next_state = display_command_pkg::st_wait;
            end
         end
         display_command_pkg::st_wait: begin
            if (op == display_command_pkg::op_inc) begin
               next_state = display_command_pkg::st_inc;
            end else if (in_blank || immediate) begin
               next_state = display_command_pkg::st_xfer;
            end
         end
         display_command_pkg::st_xfer: begin
            if (mem_ack) begin
               if (op_block && !block_last) begin
                  // re-check blanking between each word of a block write or block read
                  next_state = display_command_pkg::st_wait;
               end else if (op_incs) begin
                  next_state = display_command_pkg::st_inc;
               end else begin
                  next_state = display_command_pkg::st_done;
               end
            end
         end
         display_command_pkg::st_inc: begin
            if (inc_end || op_incs) begin
               next_state = display_command_pkg::st_done;
            end
         end
         display_command_pkg::st_done: next_state = display_command_pkg::st_idle;
         default: next_state = display_command_pkg::st_idle;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst || is_reset) begin
         state <= display_command_pkg::st_idle;
         op <= display_command_pkg::op_rd_ptr;
         inc_count <= 3'h0;
         cursor_addr <= 14'h0000;
         latch_rdata <= 8'h00;
         latch_rvalid <= 1'b0;
      end else begin
         state <= next_state;
         latch_rvalid <= 1'b0;
         if (state == display_command_pkg::st_idle && is_delayed) begin
            op <= dec.op;
         end
         inc_count <= (state == display_command_pkg::st_inc) ? inc_count + 3'h1 : 3'h0;
         if (state == display_command_pkg::st_idle && cursor_load_en) begin
            cursor_addr <= cursor_load;
         end else if (state == display_command_pkg::st_inc && (inc_end || op_incs)) begin
            cursor_addr <= cursor_plus;
         end else if (state == display_command_pkg::st_xfer && mem_ack && op_block
            && !block_last) begin
            cursor_addr <= cursor_plus;
         end
         if (state == display_command_pkg::st_xfer && mem_ack && !op_write) begin
            latch_rdata <= mem_rdata;
            latch_rvalid <= 1'b1;
         end
      end
   end

   // block writes and block reads alike stop issuing outside blanking
   wire xfer_go = state == display_command_pkg::st_xfer;
   assign mem = '{req: xfer_go, we: op_write, addr: xfer_addr, wdata: latch_wdata};
   assign done_pulse = state == display_command_pkg::st_done;

   // ==========================================
   // status, mask and delayed-ready flag
   logic [4:0] next_status;
   always_comb begin
      next_status = status_bits;
      if (is_clr_st) begin
         next_status = next_status & ~cmd_hold[4:0];
      end
      // hardware sets win over a same-cycle clear
      next_status = next_status | (status_events & interrupt_mask);
      next_status[`BIT_READY] = next_status[`BIT_READY] | done_pulse;
   end

   always_ff @(posedge sys_clk) begin
      if (rst || is_reset) begin
         status_bits <= 5'h00;
         interrupt_mask <= 5'h00;
         delayed_ready_flag <= 1'b1;
      end else begin
         status_bits <= next_status;
         if (is_set_mask) begin
            interrupt_mask <= interrupt_mask | cmd_hold[4:0];
         end else if (is_clr_mask) begin
            interrupt_mask <= interrupt_mask & ~cmd_hold[4:0];
         end
         if (state == display_command_pkg::st_idle && is_delayed) begin
            delayed_ready_flag <= 1'b0;
         end else if (done_pulse) begin
            delayed_ready_flag <= 1'b1;
         end
      end
   end

   assign interrupt_request_output = |(status_bits & interrupt_mask);
   assign master_reset_pulse = is_reset;
endmodule

// [testbench/display_command_decoder_props.sv]
module display_command_decoder_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hblank,
   input wire logic vblank,
   input wire logic mem_ack,
   input wire logic [7:0] mem_rdata,
   input wire logic [7:0] latch_wdata,
   input wire display_command_pkg::mem_req_type mem,
   input wire logic [7:0] latch_rdata,
   input wire logic latch_rvalid,
   input wire logic [13:0] cursor_addr,
   input wire logic [3:0] init_register,
   input wire logic [4:0] status_bits,
   input wire logic [4:0] interrupt_mask,
   input wire logic delayed_ready_flag,
   input wire logic interrupt_request_output,
   input wire logic blank_out,
   input wire logic master_reset_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ==========================================
   // cycles of active screen, saturating
   logic [2:0] quiet_cnt;
   always_ff @(posedge sys_clk) begin
      if (rst || hblank || vblank || blank_out) quiet_cnt <= 3'h0;
      else if (quiet_cnt != 3'h7) quiet_cnt <= quiet_cnt + 3'h1;
   end
   sequence req_waiting;
      mem.req && !mem_ack;
   endsequence
   sequence read_taken;
      mem.req && !mem.we && mem_ack;
   endsequence
   // ==========================================
   // properties
   req_hold_a: assert property (req_waiting |=> mem.req && $stable(mem.addr))
      else $error("request dropped before answer");
   write_data_a: assert property (mem.req && mem.we |-> mem.wdata == latch_wdata)
      else $error("write data differs from latch");
   read_latch_a: assert property (read_taken |=> latch_rvalid && latch_rdata == $past(mem_rdata))
      else $error("read word not latched");
   busy_flag_a: assert property (mem.req |-> !delayed_ready_flag)
      else $error("ready flag high during transfer");
   ready_bit_a: assert property ($rose(delayed_ready_flag) && !$past(master_reset_pulse)
      |-> ##[0:1] status_bits[1]) else $error("ready bit not set");
   cursor_step_a: assert property ($changed(cursor_addr) && !$past(delayed_ready_flag)
      |-> cursor_addr == $past(cursor_addr) + 14'h1) else $error("bad cursor step");
   blank_gate_a: assert property ($rose(mem.req) |-> quiet_cnt < 3'h5)
      else $error("transfer during active screen");
   ir_range_a: assert property (init_register <= 4'he)
      else $error("pointer above fourteen");
   interrupt_request_output_level_a: assert property (interrupt_request_output == |(status_bits & interrupt_mask))
      else $error("interrupt output wrong");
endmodule

bind display_command_decoder display_command_decoder_props display_command_decoder_props_inst (
   .sys_clk, .rst, .hblank, .vblank, .mem_ack, .mem_rdata, .latch_wdata, .mem, .latch_rdata,
   .latch_rvalid, .cursor_addr, .init_register, .status_bits, .interrupt_mask,
   .delayed_ready_flag, .interrupt_request_output, .blank_out, .master_reset_pulse);

// [testbench/display_buffer_model.sv]
module display_buffer_model #(
   parameter int ACK_DELAY = 2
) (
   input wire logic sys_clk,
   input wire display_command_pkg::mem_req_type mem,
   output logic [7:0] rdata,
   output logic ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] store [0:16383];
   int wait_cnt = 0;
   initial begin
      rdata = 8'h00;
      ack = 1'b0;
   end
   always @(posedge sys_clk) begin
      ack <= 1'b0;
      // idle bus toggles so a stale byte is never mistaken for data
      rdata <= ~rdata;
      if (mem.req === 1'b1 && ack !== 1'b1) begin
         if (wait_cnt >= ACK_DELAY) begin
            ack <= 1'b1;
            wait_cnt <= 0;
            rdata <= store[mem.addr];
            if (mem.we) store[mem.addr] <= mem.wdata;
         end else wait_cnt <= wait_cnt + 1;
      end
   end
endmodule

// [testbench/display_command_decoder_tb_top.sv]
module display_command_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, cmd_write_n, hblank, vblank, field_start, line_start, mem_ack;
   logic cursor_load_en, latch_rvalid, delayed_ready_flag, interrupt_request_output;
   logic blank_out, display_address_float, graphics_enable, cursor_enable, master_reset_pulse;
   logic [7:0] cmd_data, latch_wdata, mem_rdata, latch_rdata;
   logic [4:0] status_events, status_bits, interrupt_mask;
   logic [13:0] pointer_addr, cursor_load, cursor_addr;
   logic [3:0] init_register;
   display_command_pkg::mem_req_type mem;
   int num_errors, checks_done, rd_count, mrst_count;
   display_command_decoder display_command_decoder_inst (.sys_clk, .rst, .cmd_write_n,
      .cmd_data, .hblank, .vblank, .field_start, .line_start, .status_events, .pointer_addr,
      .cursor_load, .cursor_load_en, .latch_wdata, .mem_rdata, .mem_ack, .mem, .latch_rdata,
      .latch_rvalid, .cursor_addr, .init_register, .status_bits, .interrupt_mask,
      .delayed_ready_flag, .interrupt_request_output, .blank_out, .display_address_float,
      .graphics_enable, .cursor_enable, .master_reset_pulse);
   display_buffer_model #(.ACK_DELAY(2)) display_buffer_model_inst (.sys_clk, .mem,
      .rdata(mem_rdata), .ack(mem_ack));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (latch_rvalid === 1'b1) rd_count++;
   always @(posedge sys_clk) if (master_reset_pulse === 1'b1) mrst_count++;
   // ==========================================
   // helpers
   task end_sim;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task check(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // strobe low three clocks so the synchroniser sees it
   task send(input logic [7:0] b);
      cmd_data = b;
      cmd_write_n = 1'b0;
      tick(3);
      cmd_write_n = 1'b1;
      tick(6);
   endtask
   task wait_rdy(input int n);
      for (int i = 0; i < n && delayed_ready_flag !== 1'b1; i++) tick(1);
      check(delayed_ready_flag, 1'b1);
      if (delayed_ready_flag !== 1'b1) end_sim;
   endtask
   task pulse(input logic field);
      if (field) field_start = 1'b1;
      else line_start = 1'b1;
      tick(1);
      field_start = 1'b0;
      line_start = 1'b0;
      tick(6);
   endtask
   task do_cmd(input logic [7:0] b, input int n);
      send(b);
      wait_rdy(n);
   endtask
   // ==========================================
   // scenarios
   task t_reset;
      check({blank_out, delayed_ready_flag, init_register}, 6'h30);
      check({status_bits, interrupt_mask}, 10'h000);
   endtask
   task t_ir;
      send(8'h1e);
      check(init_register, 4'he);
      send(8'h1f);
      check(init_register, 4'he);
   endtask
   task t_mode;
      send(8'h3b);
      check({graphics_enable, cursor_enable}, 2'h3);
      pulse(1'b0);
      check(blank_out, 1'b0);
      send(8'h2e);
      check({blank_out, display_address_float, graphics_enable}, 3'h6);
      send(8'h2d);
      pulse(1'b0);
      check(blank_out, 1'b1);
      pulse(1'b1);
      check({blank_out, display_address_float, cursor_enable}, 3'h1);
   endtask
   task t_irq;
      send(8'h7f);
      check(interrupt_mask, 5'h1f);
      status_events = 5'h1d;
      tick(1);
      status_events = 5'h00;
      tick(2);
      check({status_bits, interrupt_request_output}, 6'h3b);
      send(8'h45);
      check(status_bits, 5'h18);
      send(8'h88);
      check(interrupt_mask, 5'h17);
      send(8'h5f);
      check({status_bits, delayed_ready_flag, interrupt_request_output}, 7'h02);
      send(8'hff);
      send(8'hc5);
      check({status_bits, interrupt_mask, init_register}, 14'h017e);
   endtask
   task t_ptr;
      pointer_addr = 14'h0010;
      latch_wdata = 8'h5a;
      do_cmd(8'ha2, 300);
      check(display_buffer_model_inst.store[16], 8'h5a);
      check(status_bits[1], 1'b1);
      latch_wdata = 8'h00;
      hblank = 1'b0;
      send(8'ha4);
      tick(20);
      check({delayed_ready_flag, mem.req}, 2'h0);
      hblank = 1'b1;
      wait_rdy(300);
      check(latch_rdata, 8'h5a);
   endtask
   task t_cursor;
      cursor_load = 14'h3fff;
      cursor_load_en = 1'b1;
      tick(1);
      cursor_load_en = 1'b0;
      hblank = 1'b0;
      do_cmd(8'ha9, 8);
      check(cursor_addr, 14'h0000);
      hblank = 1'b1;
      latch_wdata = 8'h11;
      do_cmd(8'haa, 300);
      check({display_buffer_model_inst.store[0], cursor_addr}, 22'h044000);
      latch_wdata = 8'h22;
      do_cmd(8'hab, 300);
      check({display_buffer_model_inst.store[0], cursor_addr}, 22'h088001);
      display_buffer_model_inst.store[1] = 8'h33;
      display_buffer_model_inst.store[2] = 8'h44;
      do_cmd(8'had, 300);
      check({latch_rdata, cursor_addr}, 22'h0cc002);
      do_cmd(8'hac, 300);
      check({latch_rdata, cursor_addr}, 22'h110002);
   endtask
   task t_block;
      pointer_addr = 14'h0005;
      latch_wdata = 8'h77;
      send(8'hbb);
      // active screen after the first word: the block must hold
      hblank = 1'b0;
      tick(20);
      check({delayed_ready_flag, mem.req, cursor_addr}, 16'h0003);
      hblank = 1'b1;
      wait_rdy(600);
      for (int a = 2; a < 6; a++) check(display_buffer_model_inst.store[a], 8'h77);
      check(cursor_addr, 14'h0005);
      cursor_load = 14'h0003;
      cursor_load_en = 1'b1;
      tick(1);
      cursor_load_en = 1'b0;
      display_buffer_model_inst.store[5] = 8'h63;
      rd_count = 0;
      do_cmd(8'hbd, 600);
      check({rd_count[7:0], latch_rdata}, 16'h0363);
      check(cursor_addr, 14'h0005);
   endtask
   task t_master;
      send(8'h00);
      check({blank_out, delayed_ready_flag, init_register, graphics_enable, cursor_enable},
         8'hc0);
      check({status_bits, interrupt_mask, cursor_addr}, 24'h000000);
      check(mrst_count, 1);
   endtask
   initial begin
      rst = 1'b1;
      {cmd_write_n, hblank, vblank, field_start, line_start} = 5'h18;
      {cmd_data, latch_wdata, status_events} = 21'h000000;
      {pointer_addr, cursor_load, cursor_load_en} = 29'h00000000;
      num_errors = 0;
      checks_done = 0;
      rd_count = 0;
      mrst_count = 0;
      tick(4);
      rst = 1'b0;
      tick(1);
      t_reset;
      t_ir;
      t_mode;
      t_irq;
      t_ptr;
      t_cursor;
      t_block;
      t_master;
      end_sim;
   end
endmodule
